// ==== design/eg_defs.svh ====
`ifndef EG_DEFS_SVH
`define EG_DEFS_SVH

// Group, batch and node structure
`define EG_GROUPS 2
`define EG_GRP_W 1
`define EG_BATCHES 2
`define EG_BATCH_NODES 4
`define EG_GROUP_NODES 8
`define EG_ALL_BATCHES 4
`define EG_ALL_NODES 16
`define EG_NODE_ID_W 2

// Error_group_control_status layout
`define EG_CODE_W 2
`define EG_EN_LSB 2
`define EG_NODE_EN_RST 16'hFFFF

// Alarm type codes
`define EG_CODE_NONE 2'h0
`define EG_CODE_COR_OVF 2'h1
`define EG_CODE_UNC 2'h2
`define EG_CODE_UNC_OVF 2'h3

// Error counters
`define EG_UNC_CNT_W 4
`define EG_UNC_THRESH 4'h3
`define EG_COR_CNT_W 4

// Error_group_control_status numbers and trap causes
`define EG_CSR_ADDR_W 12
`define EG_CSR_BASE 12'h7C0
`define EG_CAUSE_W 5
`define EG_TRAP_BASE 5'h18

// APB register offsets of the core-side controller
`define EG_APB_ADDR_W 8
`define EG_REG_CSR_NUM 8'h00
`define EG_REG_CSR_WDATA 8'h04
`define EG_REG_CMD 8'h08
`define EG_REG_CSR_RDATA 8'h0C
`define EG_REG_TRAP 8'h10
`define EG_TRAP_BATCH_LSB 8
`define EG_CMD_START 0
`define EG_CMD_WRITE 1

`endif

// ==== design/eg_pkg.sv ====
package eg_pkg;
    // CSR access sequencer of the core-side controller
    typedef enum logic [0:0] {
        EG_IDLE,
        EG_BUSY
    } eg_csr_state_t;
endpackage

// ==== design/eg_link_if.sv ====
`include "eg_defs.svh"

// Link between the fault manager and the core
interface eg_link_if;
    logic csr_req;                                // Access request, held until ack
    logic csr_we;                                 // Write when high
    logic [`EG_CSR_ADDR_W-1:0] csr_addr;          // Error_group_control_status number
    logic [31:0] csr_wdata;                       // Write data
    logic csr_ack;                                // One-cycle answer
    logic [31:0] csr_rdata;                       // Read data, valid with ack
    logic [`EG_GROUPS-1:0] alarm;                 // One alarm per group
    logic [`EG_GROUPS*`EG_BATCHES-1:0] batch_id;  // Batches that alarmed

    modport dev (
        input csr_req, csr_we, csr_addr, csr_wdata,
        output csr_ack, csr_rdata, alarm, batch_id
    );
    modport core (
        output csr_req, csr_we, csr_addr, csr_wdata,
        input csr_ack, csr_rdata, alarm, batch_id
    );
endinterface

// ==== design/eg_safety_fault_manager.sv ====
`include "eg_defs.svh"

module eg_safety_fault_manager (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`EG_ALL_NODES-1:0] node_unc_err_i,
    input wire logic [`EG_ALL_NODES-1:0] node_cor_err_i,
    output logic [`EG_ALL_BATCHES*`EG_NODE_ID_W-1:0] batch_node_id_o,
    output logic [`EG_ALL_BATCHES*`EG_CODE_W-1:0] batch_err_type_o,
    eg_link_if.dev link
);

    // Alarm code from the three causes, uncorrected first
    function automatic logic [`EG_CODE_W-1:0] alarm_code(input logic unc, input logic uovf,
                                                         input logic covf);
        if (unc && uovf) begin
            alarm_code = `EG_CODE_UNC_OVF;
        end else if (unc) begin
            alarm_code = `EG_CODE_UNC;
        end else if (uovf) begin
            // Overflow without a live error flag is still the worst case
            alarm_code = `EG_CODE_UNC_OVF;
        end else if (covf) begin
            alarm_code = `EG_CODE_COR_OVF;
        end else begin
            alarm_code = `EG_CODE_NONE;
        end
    endfunction

    // Lowest-numbered reporting node wins
    function automatic logic [`EG_NODE_ID_W-1:0] first_node(
        input logic [`EG_BATCH_NODES-1:0] hits);
        first_node = '0;
        for (int i = `EG_BATCH_NODES - 1; i >= 0; i--) begin
            if (hits[i]) begin
                first_node = i[`EG_NODE_ID_W-1:0];
            end
        end
    endfunction

    // Node report enables, all groups side by side
    logic [`EG_ALL_NODES-1:0] node_en;
    // Sticky cause flags per batch
    logic [`EG_ALL_BATCHES-1:0] flag_unc;
    logic [`EG_ALL_BATCHES-1:0] flag_uovf;
    logic [`EG_ALL_BATCHES-1:0] flag_covf;
    logic [`EG_ALL_BATCHES-1:0] next_flag_unc;
    logic [`EG_ALL_BATCHES-1:0] next_flag_uovf;
    logic [`EG_ALL_BATCHES-1:0] next_flag_covf;
    // Per-batch error counters
    logic [`EG_UNC_CNT_W-1:0] unc_cnt [`EG_ALL_BATCHES];
    logic [`EG_COR_CNT_W-1:0] cor_cnt [`EG_ALL_BATCHES];
    // Events of this cycle
    logic [`EG_ALL_BATCHES-1:0] unc_evt;
    logic [`EG_ALL_BATCHES-1:0] uovf_evt;
    logic [`EG_ALL_BATCHES-1:0] covf_evt;
    logic [`EG_ALL_BATCHES-1:0] cor_seen;
    // Enables that hardware drops this cycle
    logic [`EG_ALL_NODES-1:0] en_drop;
    // Node id candidate per batch
    logic [`EG_ALL_BATCHES*`EG_NODE_ID_W-1:0] next_node_id;

    // CSR decode
    logic csr_take;
    logic addr_ok;
    logic [`EG_CSR_ADDR_W-1:0] addr_off;
    logic [`EG_GRP_W-1:0] grp_sel;
    logic wr_take;
    logic [`EG_GROUPS-1:0] code_clear;

    // A held request is taken once, on the edge before its ack
    assign csr_take = link.csr_req && !link.csr_ack;
    assign addr_off = link.csr_addr - `EG_CSR_BASE;
    assign addr_ok = (link.csr_addr >= `EG_CSR_BASE) &&
                     (addr_off < `EG_CSR_ADDR_W'(`EG_GROUPS));
    assign grp_sel = addr_off[`EG_GRP_W-1:0];
    assign wr_take = csr_take && link.csr_we && addr_ok;

    // Writing code 00 acknowledges every cause of the group
    always_comb begin
        for (int g = 0; g < `EG_GROUPS; g++) begin
            code_clear[g] = wr_take && (grp_sel == g[`EG_GRP_W-1:0]) &&
                            (link.csr_wdata[`EG_CODE_W-1:0] == `EG_CODE_NONE);
        end
    end

    // Batch units: masking, counting, events and next flags
    always_comb begin
        logic [`EG_BATCH_NODES-1:0] uh;
        logic [`EG_BATCH_NODES-1:0] ch;
        logic clr;
        uh = '0;
        ch = '0;
        clr = 1'b0;
        for (int b = 0; b < `EG_ALL_BATCHES; b++) begin
            // Disabled nodes are invisible to the batch
            uh = node_unc_err_i[b*`EG_BATCH_NODES +: `EG_BATCH_NODES] &
                 node_en[b*`EG_BATCH_NODES +: `EG_BATCH_NODES];
            ch = node_cor_err_i[b*`EG_BATCH_NODES +: `EG_BATCH_NODES] &
                 node_en[b*`EG_BATCH_NODES +: `EG_BATCH_NODES];
            clr = code_clear[b / `EG_BATCHES];
            unc_evt[b] = |uh;
            // Count goes above threshold on this error
            uovf_evt[b] = (|uh) && (unc_cnt[b] >= `EG_UNC_THRESH);
            cor_seen[b] = |ch;
            covf_evt[b] = (|ch) && (&cor_cnt[b]);
            // Events win over a clear in the same cycle
            next_flag_unc[b] = unc_evt[b] || (flag_unc[b] && !clr);
            next_flag_uovf[b] = uovf_evt[b] || (flag_uovf[b] && !clr);
            next_flag_covf[b] = covf_evt[b] || (flag_covf[b] && !clr);
            // Responsible nodes lose their enable
            en_drop[b*`EG_BATCH_NODES +: `EG_BATCH_NODES] =
                uh | (covf_evt[b] ? ch : '0);
            next_node_id[b*`EG_NODE_ID_W +: `EG_NODE_ID_W] =
                (|uh) ? first_node(uh) : first_node(ch);
        end
    end

    // Uncorrected counters saturate so overflow stays reported
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < `EG_ALL_BATCHES; b++) begin
            if (rst_i) begin
                unc_cnt[b] <= '0;
            end else if (unc_evt[b] && !(&unc_cnt[b])) begin
                unc_cnt[b] <= unc_cnt[b] + `EG_UNC_CNT_W'(1);
            end
        end
    end

    // Corrected counters wrap; the wrap is the overflow
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < `EG_ALL_BATCHES; b++) begin
            if (rst_i) begin
                cor_cnt[b] <= '0;
            end else if (cor_seen[b]) begin
                cor_cnt[b] <= cor_cnt[b] + `EG_COR_CNT_W'(1);
            end
        end
    end

    // Sticky cause flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_unc <= '0;
            flag_uovf <= '0;
            flag_covf <= '0;
        end else begin
            flag_unc <= next_flag_unc;
            flag_uovf <= next_flag_uovf;
            flag_covf <= next_flag_covf;
        end
    end

    // Node enables: hardware drop beats a software set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            node_en <= `EG_NODE_EN_RST;
        end else begin
            for (int n = 0; n < `EG_ALL_NODES; n++) begin
                if (en_drop[n]) begin
                    node_en[n] <= 1'b0;
                end else if (wr_take && (grp_sel == `EG_GRP_W'(n / `EG_GROUP_NODES))) begin
                    node_en[n] <= link.csr_wdata[`EG_EN_LSB + (n % `EG_GROUP_NODES)];
                end
            end
        end
    end

    // Batch outputs: type follows the flags, id follows the last event
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < `EG_ALL_BATCHES; b++) begin
            if (rst_i) begin
                batch_err_type_o[b*`EG_CODE_W +: `EG_CODE_W] <= `EG_CODE_NONE;
                batch_node_id_o[b*`EG_NODE_ID_W +: `EG_NODE_ID_W] <= '0;
            end else begin
                batch_err_type_o[b*`EG_CODE_W +: `EG_CODE_W] <=
                    alarm_code(next_flag_unc[b], next_flag_uovf[b], next_flag_covf[b]);
                if (unc_evt[b] || covf_evt[b]) begin
                    batch_node_id_o[b*`EG_NODE_ID_W +: `EG_NODE_ID_W] <=
                        next_node_id[b*`EG_NODE_ID_W +: `EG_NODE_ID_W];
                end
            end
        end
    end

    // Group stage: batch alarms OR into one alarm per group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.alarm <= '0;
            link.batch_id <= '0;
        end else begin
            for (int b = 0; b < `EG_ALL_BATCHES; b++) begin
                link.batch_id[b] <= next_flag_unc[b] || next_flag_uovf[b] ||
                                    next_flag_covf[b];
            end
            for (int g = 0; g < `EG_GROUPS; g++) begin
                link.alarm[g] <= |(next_flag_unc[g*`EG_BATCHES +: `EG_BATCHES] |
                                   next_flag_uovf[g*`EG_BATCHES +: `EG_BATCHES] |
                                   next_flag_covf[g*`EG_BATCHES +: `EG_BATCHES]);
            end
        end
    end

    // CSR answer one cycle after the take; reads show pre-write state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.csr_ack <= 1'b0;
            link.csr_rdata <= '0;
        end else begin
            link.csr_ack <= csr_take;
            if (csr_take) begin
                link.csr_rdata <= '0;
                if (addr_ok) begin
                    // Upper bits of absent nodes read as zero
                    link.csr_rdata[`EG_EN_LSB +: `EG_GROUP_NODES] <=
                        node_en[grp_sel*`EG_GROUP_NODES +: `EG_GROUP_NODES];
                    link.csr_rdata[`EG_CODE_W-1:0] <= alarm_code(
                        |flag_unc[grp_sel*`EG_BATCHES +: `EG_BATCHES],
                        |flag_uovf[grp_sel*`EG_BATCHES +: `EG_BATCHES],
                        |flag_covf[grp_sel*`EG_BATCHES +: `EG_BATCHES]);
                end
            end
        end
    end

endmodule

// ==== design/eg_core_ctrl.sv ====
`include "eg_defs.svh"

// Core-side end: CSR access sequencer and trap raiser, driven over APB
module eg_core_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`EG_APB_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic trap_req_o,
    output logic [`EG_CAUSE_W-1:0] trap_cause_o,
    input wire logic trap_ack_i,
    eg_link_if.core link
);

    eg_pkg::eg_csr_state_t state;                 // Sequencer state
    logic [`EG_CSR_ADDR_W-1:0] csr_num;           // Target CSR number
    logic [31:0] csr_wdata;                       // Data to write
    logic [31:0] csr_rdata;                       // Last data read
    logic [`EG_GROUPS-1:0] alarm_q;               // Alarm one cycle ago
    logic [`EG_GROUPS-1:0] pending;               // Groups awaiting a trap
    logic [`EG_GRP_W-1:0] grp_pick;               // Lowest pending group
    logic apb_do;                                 // Access phase, answer this edge
    logic start;                                  // Command register strobe
    logic apb_wr; // Write completing at this edge

    // Answer in the second access cycle, so pready is a plain flop
    assign apb_do = psel_i && penable_i && !pready_o;
    // Writes land only at the edge where the master sees pready
    assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
    assign start = apb_wr && (paddr_i == `EG_REG_CMD) && pwdata_i[`EG_CMD_START];

    // Lowest pending group gets the trap first
    always_comb begin
        grp_pick = '0;
        for (int g = `EG_GROUPS - 1; g >= 0; g--) begin
            if (pending[g]) begin
                grp_pick = g[`EG_GRP_W-1:0];
            end
        end
    end

    // Setup registers; a write never lands before the transfer completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            csr_num <= `EG_CSR_BASE;
            csr_wdata <= '0;
        end else if (apb_wr && (paddr_i == `EG_REG_CSR_NUM)) begin
            csr_num <= pwdata_i[`EG_CSR_ADDR_W-1:0];
        end else if (apb_wr && (paddr_i == `EG_REG_CSR_WDATA)) begin
            csr_wdata <= pwdata_i;
        end
    end

    // APB slave: answer, read data and error for unmapped offsets
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= apb_do;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            if (apb_do) begin
                case (paddr_i)
                    `EG_REG_CSR_NUM: begin
                        prdata_o[`EG_CSR_ADDR_W-1:0] <= csr_num;
                    end
                    `EG_REG_CSR_WDATA: begin
                        prdata_o <= csr_wdata;
                    end
                    `EG_REG_CMD: begin
                        prdata_o[`EG_CMD_START] <= (state == eg_pkg::EG_BUSY);
                    end
                    `EG_REG_CSR_RDATA: begin
                        prdata_o <= csr_rdata;
                    end
                    `EG_REG_TRAP: begin
                        prdata_o[`EG_GROUPS-1:0] <= pending;
                        prdata_o[`EG_TRAP_BATCH_LSB +: `EG_GROUPS*`EG_BATCHES] <=
                            link.batch_id;
                    end
                    default: begin
                        // Unmapped offset
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // CSR sequencer; a start while busy is ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= eg_pkg::EG_IDLE;
            link.csr_req <= 1'b0;
            link.csr_we <= 1'b0;
            link.csr_addr <= `EG_CSR_BASE;
            link.csr_wdata <= '0;
            csr_rdata <= '0;
        end else begin
            case (state)
                eg_pkg::EG_IDLE: begin
                    if (start) begin
                        link.csr_req <= 1'b1;
                        link.csr_we <= pwdata_i[`EG_CMD_WRITE];
                        link.csr_addr <= csr_num;
                        link.csr_wdata <= csr_wdata;
                        state <= eg_pkg::EG_BUSY;
                    end
                end
                eg_pkg::EG_BUSY: begin
                    if (link.csr_ack) begin
                        link.csr_req <= 1'b0;
                        csr_rdata <= link.csr_rdata;
                        state <= eg_pkg::EG_IDLE;
                    end
                end
                default: begin
                    state <= eg_pkg::EG_IDLE;
                    link.csr_req <= 1'b0;
                end
            endcase
        end
    end

    // Rising group alarm marks its trap pending; a new rise wins over ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= '0;
            pending <= '0;
        end else begin
            alarm_q <= link.alarm;
            for (int g = 0; g < `EG_GROUPS; g++) begin
                if (link.alarm[g] && !alarm_q[g]) begin
                    pending[g] <= 1'b1;
                end else if (trap_ack_i && trap_req_o && (trap_cause_o ==
                             `EG_TRAP_BASE + `EG_CAUSE_W'(g))) begin
                    pending[g] <= 1'b0;
                end
            end
        end
    end

    // Trap request with a distinct cause per group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_req_o <= 1'b0;
            trap_cause_o <= `EG_TRAP_BASE;
        end else if (!trap_req_o || trap_ack_i) begin
            // Cause only changes when no request stands or the standing one is acked
            trap_req_o <= |(pending & ~(trap_ack_i ? (`EG_GROUPS'(1) << grp_pick) : '0));
            trap_cause_o <= `EG_TRAP_BASE + `EG_CAUSE_W'(grp_pick);
        end
    end

endmodule

// ==== dv/eg_link_monitor.sv ====
`include "eg_defs.svh"

// Watches the CSR link and the group alarms between the two ends
module eg_link_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic csr_req,
    input wire logic csr_we,
    input wire logic [`EG_CSR_ADDR_W-1:0] csr_addr,
    input wire logic [31:0] csr_wdata,
    input wire logic csr_ack,
    input wire logic [31:0] csr_rdata,
    input wire logic [`EG_GROUPS-1:0] alarm,
    input wire logic [`EG_GROUPS*`EG_BATCHES-1:0] batch_id
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [`EG_GROUPS-1:0] clr;  // Clearing write taken this edge, per group

    // Request taken at this edge
    sequence s_take;
        csr_req && !csr_ack;
    endsequence

    // One-cycle answer
    sequence s_answer;
        csr_ack ##1 !csr_ack;
    endsequence

    a_ack_after_take: assert property (s_take |=> s_answer)
        else $error("csr ack not a single pulse one cycle after request");
    a_ack_has_cause: assert property (csr_ack |-> $past(csr_req) && !$past(csr_ack))
        else $error("csr ack without a pending request");
    a_rdata_steady: assert property (!csr_ack |-> $stable(csr_rdata))
        else $error("csr read data moved outside an answer");
    a_upper_zero: assert property (csr_ack |-> csr_rdata[31:10] == 22'h0)
        else $error("csr bits above the node field not zero");
    a_unmapped_zero: assert property (csr_ack && !$past(csr_we) &&
        ($past(csr_addr) < `EG_CSR_BASE || $past(csr_addr) >= `EG_CSR_BASE + `EG_GROUPS)
        |-> csr_rdata == 32'h0)
        else $error("read of unmapped csr not zero");

    // Per-group alarm relations
    for (genvar g = 0; g < `EG_GROUPS; g++) begin : grp
        // Only a write of code 00 may drop the alarm
        assign clr[g] = csr_req && !csr_ack && csr_we && csr_addr == `EG_CSR_BASE + g
            && csr_wdata[1:0] == 2'h0;
        a_alarm_sticky: assert property (alarm[g] && !clr[g] |=> alarm[g])
            else $error("group alarm dropped without a clear");
        a_alarm_of_batches: assert property (
            alarm[g] == |batch_id[g*`EG_BATCHES +: `EG_BATCHES])
            else $error("group alarm differs from its batch alarms");
        a_code_tracks_alarm: assert property (
            csr_ack && $past(csr_addr) == `EG_CSR_BASE + g
            |-> (csr_rdata[1:0] != 2'h0) == $past(alarm[g]))
            else $error("csr alarm code disagrees with group alarm");
    end
endmodule

// ==== dv/tb_error_group_alarm_unit.sv ====
`include "eg_defs.svh"

// Fault side nodes, APB and trap ack on the core side
module tb_error_group_alarm_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] unc = 16'h0;  // Node error inputs
    logic [15:0] cor = 16'h0;
    logic psel = 1'b0;  // APB request
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic trap_ack = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trap_req;
    logic [4:0] trap_cause;
    logic [7:0] node_id;
    logic [7:0] err_type;
    int n_fail = 0;
    int n_tests = 0;
    logic [3:0] ucnt [4];  // Bench copies of the batch counters
    logic [3:0] ccnt [4];

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    eg_link_if eg_link_if_inst ();
    eg_safety_fault_manager eg_safety_fault_manager_inst (.clk_i(clk_i), .rst_i(rst_i),
        .node_unc_err_i(unc), .node_cor_err_i(cor), .batch_node_id_o(node_id),
        .batch_err_type_o(err_type), .link(eg_link_if_inst));
    eg_core_ctrl eg_core_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trap_req_o(trap_req),
        .trap_cause_o(trap_cause), .trap_ack_i(trap_ack), .link(eg_link_if_inst));
    eg_link_monitor eg_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
        .csr_req(eg_link_if_inst.csr_req), .csr_we(eg_link_if_inst.csr_we),
        .csr_addr(eg_link_if_inst.csr_addr), .csr_wdata(eg_link_if_inst.csr_wdata),
        .csr_ack(eg_link_if_inst.csr_ack), .csr_rdata(eg_link_if_inst.csr_rdata),
        .alarm(eg_link_if_inst.alarm), .batch_id(eg_link_if_inst.batch_id));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, entered just after a rising edge; idle edge after it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    // One error_group_control_status access through the controller; returns the CSR value seen
    task automatic csr(input logic wr, input logic [11:0] num, input logic [31:0] d,
                       output logic [31:0] q);
        logic e;
        apb(1'b1, `EG_REG_CSR_NUM, {20'h0, num}, q, e);
        apb(1'b1, `EG_REG_CSR_WDATA, d, q, e);
        apb(1'b1, `EG_REG_CMD, {30'h0, wr, 1'b1}, q, e);
        // Poll busy; the watchdog guards a hang
        do begin
            apb(1'b0, `EG_REG_CMD, 32'h0, q, e);
        end while (q[0] !== 1'b0);
        apb(1'b0, `EG_REG_CSR_RDATA, 32'h0, q, e);
    endtask

    // Lowest set node of a batch mask
    function automatic logic [1:0] lowest(input logic [3:0] m);
        lowest = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (m[i]) lowest = 2'(i);
        end
    endfunction

    // Uncorrected first, overflow above plain
    function automatic logic [1:0] exp_code(input logic u, input logic uo, input logic co);
        exp_code = u ? (uo ? `EG_CODE_UNC_OVF : `EG_CODE_UNC) :
                   (co ? `EG_CODE_COR_OVF : `EG_CODE_NONE);
    endfunction

    // Verdict and end of run
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the expected run
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        results();
    end

    initial begin
        logic [31:0] q;
        logic e;
        logic [3:0] um, cm, en, eu, ec, rsp;
        logic [7:0] en8;
        logic hit_u, uovf, covf;
        logic [1:0] code;
        int b, g;
        q = $urandom(32'h51EE230E);
        for (int i = 0; i < 4; i++) begin
            ucnt[i] = 4'h0;
            ccnt[i] = 4'h0;
        end
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(err_type, 8'h0);
        chk(node_id, 8'h0);
        chk(trap_req, 1'b0);
        chk(trap_cause, `EG_TRAP_BASE);
        // Reset state, refused CSR number, unmapped APB offset
        for (int k = 0; k < 2; k++) begin
            csr(1'b0, `EG_CSR_BASE + 12'(k), 32'h0, q);
            chk(q, 32'h3FC);
        end
        csr(1'b1, 12'h7C2, 32'h0, q);
        chk(q, 32'h0);
        csr(1'b0, 12'h7BF, 32'h0, q);
        chk(q, 32'h0);
        csr(1'b0, `EG_CSR_BASE, 32'h0, q);
        chk(q, 32'h3FC);
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk(e, 1'b1);
        // Random bursts: mixed masks, partial enables, counters run to overflow
        for (int it = 0; it < 120; it++) begin
            b = $urandom_range(3);
            g = b / 2;
            en = 4'($urandom | $urandom);
            um = ($urandom_range(3) == 0) ? 4'($urandom) : 4'h0;
            cm = 4'($urandom);
            en8 = 8'hFF;
            en8[(b%2)*4 +: 4] = en;
            csr(1'b1, `EG_CSR_BASE + 12'(g), {22'h0, en8, 2'h0}, q);
            eu = um & en;
            ec = cm & en;
            hit_u = |eu;
            uovf = hit_u && ucnt[b] >= `EG_UNC_THRESH;
            covf = |ec && ccnt[b] == 4'hF;
            if (hit_u && ucnt[b] != 4'hF) ucnt[b]++;
            if (|ec) ccnt[b]++;
            code = exp_code(hit_u, uovf, covf);
            rsp = eu | (covf ? ec : 4'h0);
            unc[b*4 +: 4] <= um;
            cor[b*4 +: 4] <= cm;
            @(posedge clk_i);
            unc <= 16'h0;
            cor <= 16'h0;
            @(posedge clk_i);
            chk(eg_link_if_inst.alarm, (code != 2'h0) ? (2'h1 << g) : 2'h0);
            chk(eg_link_if_inst.batch_id, (code != 2'h0) ? (4'h1 << b) : 4'h0);
            if (code != 2'h0) begin
                chk(err_type[b*2 +: 2], code);
                chk(node_id[b*2 +: 2], hit_u ? lowest(eu) : lowest(ec));
            end
            csr(1'b0, `EG_CSR_BASE + 12'(g), 32'h0, q);
            en8[(b%2)*4 +: 4] = en & ~rsp;
            chk(q, {22'h0, en8, code});
            // Trap taken, then alarm cleared by code 00
            if (code != 2'h0) begin
                chk(trap_req, 1'b1);
                chk(trap_cause, `EG_TRAP_BASE + 5'(g));
                trap_ack <= 1'b1;
                @(posedge clk_i);
                trap_ack <= 1'b0;
                // A nonzero code leaves the causes standing
                csr(1'b1, `EG_CSR_BASE + 12'(g), {22'h0, en8, 2'h1}, q);
                chk(q, {22'h0, en8, code});
                chk(eg_link_if_inst.alarm, 2'h1 << g);
                csr(1'b1, `EG_CSR_BASE + 12'(g), 32'h3FC, q);
                chk(eg_link_if_inst.alarm, 2'h0);
                chk(trap_req, 1'b0);
            end
        end
        results();
    end
endmodule
